// File: inc/dioem_link_if.sv
// Signals passed between the mapper core and its two side modules.
`timescale 1ns/100ps
interface dioem_link_if;
  import dioem_pkg::*;
  logic [NUM_IN-1:0] level;
  logic [NUM_IN-1:0] rise;
  logic [SRC_COUNT-1:0] src;
  modport sense (output level, output rise);
  modport core (input level, input rise, output src);
  modport drive (input src);
endinterface

// File: inc/dioem_pkg.sv
// Constants, types and decoders shared by the digital I/O event mapper.
// What this block does
// RULE1: There are eight input lines, each with its own action selector offering disabled, span check or zero check.
// RULE2: An input line whose action is disabled never causes any action.
// RULE3: An input's action fires once when the line enters its active state, not while it stays there.
// RULE4: An input set for span check that becomes active puts the calibration selector into span.
// RULE5: An input set for zero check that becomes active puts the calibration selector into zero; a span entry in the same cycle selects span instead.
// RULE6: Each input has its own polarity, active high meaning a 5 V level triggers and active low a 0 V level.
// RULE7: There are eight output lines, each with its own selector choosing one source state from the list.
// RULE8: Each output sits at its active level exactly while its selected state is true and inactive otherwise; in reset the code drives all outputs to 0 V.
// RULE9: Each output has its own polarity, active high driving 5 V while the state holds and active low 0 V.
// RULE10: The disabled source state is never true, so an output assigned to it stays inactive; in reset the code drives it to 0 V, active for active low.
// RULE11: The sources include power supply, converter, wheel, flow, five heater and chassis temperature faults.
// RULE12: The sources include states true while a background, a span check or a zero check runs.
// RULE13: The sources include a combined system fault, the same condition that lights the fault lamp.
// RULE14: The sources include a state true while the removable storage stick is disconnected.
// RULE15: The sources include a state true while maintenance mode is on.
// RULE16: The sources include one alternate scale state for each of analog channels 0, 1 and 2.
// RULE17: Input lines pass two synchroniser stages before polarity, and entries into the active state become one-cycle pulses.
package dioem_pkg;

  localparam int NUM_IN = 8;
  localparam int NUM_OUT = 8;
  localparam int NUM_HEAT = 5;
  localparam int ACT_W = 2;
  localparam int SRC_W = 5;
  localparam int SRC_COUNT = 20;

  localparam logic [ACT_W-1:0] ACT_DISABLED = 2'h0;
  localparam logic [ACT_W-1:0] ACT_SPAN = 2'h1;
  localparam logic [ACT_W-1:0] ACT_ZERO = 2'h2;

  localparam logic [SRC_W-1:0] SRC_DISABLED = 5'h00;
  localparam logic [SRC_W-1:0] SRC_PSU = 5'h01;
  localparam logic [SRC_W-1:0] SRC_CONVERTER = 5'h02;
  localparam logic [SRC_W-1:0] SRC_WHEEL = 5'h03;
  localparam logic [SRC_W-1:0] SRC_FLOW = 5'h04;
  localparam logic [SRC_W-1:0] SRC_HEAT_BASE = 5'h05;
  localparam logic [SRC_W-1:0] SRC_CHASSIS = 5'h0A;
  localparam logic [SRC_W-1:0] SRC_USB_OFF = 5'h0B;
  localparam logic [SRC_W-1:0] SRC_BACKGROUND = 5'h0C;
  localparam logic [SRC_W-1:0] SRC_SPAN = 5'h0D;
  localparam logic [SRC_W-1:0] SRC_ZERO = 5'h0E;
  localparam logic [SRC_W-1:0] SRC_SYS_FAULT = 5'h0F;
  localparam logic [SRC_W-1:0] SRC_MAINT = 5'h10;
  localparam logic [SRC_W-1:0] SRC_CH0_ALT = 5'h11;
  localparam logic [SRC_W-1:0] SRC_CH1_ALT = 5'h12;
  localparam logic [SRC_W-1:0] SRC_CH2_ALT = 5'h13;

  localparam logic [NUM_IN-1:0] SYNC_RST = 8'h00;
  localparam logic [NUM_IN-1:0] PREV_RST = 8'hFF;
  localparam logic [1:0] FILL_RST = 2'h0;
  localparam logic [NUM_OUT-1:0] OUT_RST = 8'h00;

  typedef enum logic [2:0] {
    CAL_MEASURE = 3'h1,
    CAL_SPAN = 3'h2,
    CAL_ZERO = 3'h4
  } dioem_cal_e;

  // Picks one source state; the disabled code and unused codes read false.
  function automatic logic dioem_pick(input logic [SRC_COUNT-1:0] v,
                                      input logic [SRC_W-1:0] s);
    logic r;
    r = 1'b0;
    if (s != SRC_DISABLED && s <= SRC_CH2_ALT) begin
      r = v[s];
    end
    return r;
  endfunction

  // Marks every input whose action selector holds the given code.
  function automatic logic [NUM_IN-1:0] dioem_act_mask(
      input logic [NUM_IN*ACT_W-1:0] a, input logic [ACT_W-1:0] code);
    logic [NUM_IN-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      m[i] = (a[i*ACT_W +: ACT_W] == code);
    end
    return m;
  endfunction

endpackage

// File: rtl/dioem_in_sense.sv
// Input line synchroniser, polarity correction and entry detection.
`timescale 1ns/100ps
module dioem_in_sense
  import dioem_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [NUM_IN-1:0] i_input_line,
  input wire logic [NUM_IN-1:0] i_in_active_high,
  dioem_link_if.sense lk
);

  logic [NUM_IN-1:0] sync1_q;
  logic [NUM_IN-1:0] sync2_q;
  logic [NUM_IN-1:0] prev_q;
  logic [1:0] fill_q;
  wire [NUM_IN-1:0] active;
  wire [NUM_IN-1:0] prev_d;

  // RULE6: polarity correction per line.
  assign active = ~(sync2_q ^ i_in_active_high);
  assign lk.level = active;
  // RULE3: fire only on entry.
  assign lk.rise = active & ~prev_q;
  // RULE3: no entry before fill.
  assign prev_d = fill_q[1] ? active : PREV_RST;

  // RULE17: two stage synchroniser.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sync1_q <= SYNC_RST;
      sync2_q <= SYNC_RST;
      prev_q <= PREV_RST;
      fill_q <= FILL_RST;
    end else begin
      sync1_q <= i_input_line;
      sync2_q <= sync1_q;
      prev_q <= prev_d;
      fill_q <= {fill_q[0], 1'b1};
    end
  end

endmodule // dioem_in_sense

// File: rtl/dioem_out_drive.sv
// Output line source selection and polarity.
`timescale 1ns/100ps
module dioem_out_drive
  import dioem_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [NUM_OUT*SRC_W-1:0] i_out_source,
  input wire logic [NUM_OUT-1:0] i_out_active_high,
  dioem_link_if.drive lk,
  output logic [NUM_OUT-1:0] o_output_line
);

  wire [NUM_OUT-1:0] hit;
  wire [NUM_OUT-1:0] line_d;

  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++) begin : g_line
      // RULE7: per line source selector.
      assign hit[g] = dioem_pick(lk.src, i_out_source[g*SRC_W +: SRC_W]);
      // RULE9: per line polarity.
      assign line_d[g] = ~(hit[g] ^ i_out_active_high[g]);
    end
  endgenerate

  // RULE8: output follows its state.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_output_line <= OUT_RST;
    end else begin
      o_output_line <= line_d;
    end
  end

endmodule // dioem_out_drive

// File: rtl/dioem_top.sv
// Top of the digital I/O event mapper: actions, calibration and sources.
`timescale 1ns/100ps
module dioem_top
  import dioem_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [NUM_IN-1:0] i_input_line,
  input wire logic [NUM_IN*ACT_W-1:0] i_in_action,
  input wire logic [NUM_IN-1:0] i_in_active_high,
  input wire logic [NUM_OUT*SRC_W-1:0] i_out_source,
  input wire logic [NUM_OUT-1:0] i_out_active_high,
  input wire logic i_cal_finish,
  input wire logic i_psu_fault,
  input wire logic i_converter_fault,
  input wire logic i_wheel_fault,
  input wire logic i_flow_fault,
  input wire logic [NUM_HEAT-1:0] i_heater_fault,
  input wire logic i_chassis_temp_fault,
  input wire logic i_other_fault,
  input wire logic i_usb_present,
  input wire logic i_background_busy,
  input wire logic i_maintenance,
  input wire logic [2:0] i_alt_scale,
  output logic [NUM_OUT-1:0] o_output_line,
  output logic [2:0] o_cal_mode,
  output logic o_cal_start,
  output logic o_fault_lamp
);

  // ************************************************************
  // Side modules.
  // ************************************************************

  dioem_link_if lk ();

  dioem_in_sense u_sense (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_input_line(i_input_line),
    .i_in_active_high(i_in_active_high),
    .lk(lk.sense)
  );

  dioem_out_drive u_drive (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_out_source(i_out_source),
    .i_out_active_high(i_out_active_high),
    .lk(lk.drive),
    .o_output_line(o_output_line)
  );

  // ************************************************************
  // Input actions.
  // ************************************************************

  wire [NUM_IN-1:0] span_mask;
  wire [NUM_IN-1:0] zero_mask;
  wire span_req;
  wire zero_req;

  // RULE1: decode each line's action.
  assign span_mask = dioem_act_mask(i_in_action, ACT_SPAN);
  assign zero_mask = dioem_act_mask(i_in_action, ACT_ZERO);
  // RULE2: disabled lines are in neither mask.
  assign span_req = |(lk.rise & span_mask);
  assign zero_req = |(lk.rise & zero_mask);

  // ************************************************************
  // Calibration selector.
  // ************************************************************

  dioem_cal_e cal_q;
  dioem_cal_e cal_d;
  logic start_d;

  always_comb begin
    cal_d = cal_q;
    start_d = 1'b0;
    unique case (cal_q)
      CAL_MEASURE: begin
        // RULE4: span entry.
        if (span_req) begin
          cal_d = CAL_SPAN;
          start_d = 1'b1;
        // RULE5: zero entry.
        end else if (zero_req) begin
          cal_d = CAL_ZERO;
          start_d = 1'b1;
        end
      end
      CAL_SPAN, CAL_ZERO: begin
        if (span_req) begin
          cal_d = CAL_SPAN;
          start_d = 1'b1;
        end else if (zero_req) begin
          cal_d = CAL_ZERO;
          start_d = 1'b1;
        end else if (i_cal_finish) begin
          cal_d = CAL_MEASURE;
        end
      end
      default: begin
        cal_d = CAL_MEASURE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      cal_q <= CAL_MEASURE;
      o_cal_start <= 1'b0;
    end else begin
      cal_q <= cal_d;
      o_cal_start <= start_d;
    end
  end

  assign o_cal_mode = cal_q;

  // ************************************************************
  // Source states.
  // ************************************************************

  wire any_fault;

  // RULE13: combined system fault.
  assign any_fault = i_psu_fault | i_converter_fault | i_wheel_fault |
                     i_flow_fault | (|i_heater_fault) |
                     i_chassis_temp_fault | i_other_fault;

  // RULE10: disabled source is never true.
  assign lk.src[SRC_DISABLED] = 1'b0;
  // RULE11: individual fault flags.
  assign lk.src[SRC_PSU] = i_psu_fault;
  assign lk.src[SRC_CONVERTER] = i_converter_fault;
  assign lk.src[SRC_WHEEL] = i_wheel_fault;
  assign lk.src[SRC_FLOW] = i_flow_fault;
  assign lk.src[SRC_HEAT_BASE +: NUM_HEAT] = i_heater_fault;
  assign lk.src[SRC_CHASSIS] = i_chassis_temp_fault;
  // RULE14: storage stick absent.
  assign lk.src[SRC_USB_OFF] = ~i_usb_present;
  // RULE12: activity states; RULE13: combined system fault.
  assign lk.src[SRC_BACKGROUND] = i_background_busy;
  assign lk.src[SRC_SPAN] = (cal_q == CAL_SPAN);
  assign lk.src[SRC_ZERO] = (cal_q == CAL_ZERO);
  assign lk.src[SRC_SYS_FAULT] = any_fault;
  // RULE15: maintenance mode.
  assign lk.src[SRC_MAINT] = i_maintenance;
  // RULE16: alternate scale per channel.
  assign lk.src[SRC_CH0_ALT] = i_alt_scale[0];
  assign lk.src[SRC_CH1_ALT] = i_alt_scale[1];
  assign lk.src[SRC_CH2_ALT] = i_alt_scale[2];

  // RULE13: fault lamp.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_fault_lamp <= 1'b0;
    end else begin
      o_fault_lamp <= any_fault;
    end
  end

  // ************************************************************
  // Checks.
  // ************************************************************

  logic [1:0] settle_q;
  wire [NUM_OUT-1:0] hit_chk;
  wire [NUM_OUT-1:0] off_chk;
  wire [NUM_OUT-1:0] exp_chk;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      settle_q <= 2'h0;
    end else begin
      settle_q <= {settle_q[0], 1'b1};
    end
  end

  genvar c;
  generate
    for (c = 0; c < NUM_OUT; c++) begin : g_chk
      assign hit_chk[c] = dioem_pick(lk.src,
                                     i_out_source[c*SRC_W +: SRC_W]);
      assign off_chk[c] = (i_out_source[c*SRC_W +: SRC_W] == SRC_DISABLED);
      assign exp_chk[c] = ~(hit_chk[c] ^ i_out_active_high[c]);
    end
  endgenerate

  property p_span_entry; // RULE4
    @(posedge i_mclk) disable iff (i_reset)
      span_req |=> (cal_q == CAL_SPAN) && o_cal_start;
  endproperty
  a_span_entry: assert property (p_span_entry) // RULE4
    else $error("Span request did not select span.");

  property p_zero_entry; // RULE5
    @(posedge i_mclk) disable iff (i_reset)
      zero_req && !span_req |=>
        (cal_q == CAL_ZERO) && o_cal_start && lk.src[SRC_ZERO];
  endproperty
  a_zero_entry: assert property (p_zero_entry) // RULE5
    else $error("Zero request did not select zero.");

  property p_disabled_quiet; // RULE2
    @(posedge i_mclk) disable iff (i_reset)
      !span_req && !zero_req && !i_cal_finish |=>
        $stable(cal_q) && !o_cal_start;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) // RULE2
    else $error("Calibration changed without a request.");

  property p_rise_once; // RULE3
    @(posedge i_mclk) disable iff (i_reset)
      (|lk.rise) |=> (lk.rise & $past(lk.rise)) == '0;
  endproperty
  a_rise_once: assert property (p_rise_once) // RULE3
    else $error("Input fired twice in a row.");

  property p_rise_entry; // RULE17
    @(posedge i_mclk) disable iff (i_reset)
      (|lk.rise) |-> ((lk.rise & ~lk.level) == '0) &&
                     ((lk.rise & $past(lk.level)) == '0);
  endproperty
  a_rise_entry: assert property (p_rise_entry) // RULE17
    else $error("Input pulse without entry into active.");

  property p_in_polarity; // RULE6
    @(posedge i_mclk) disable iff (i_reset)
      settle_q[1] && $stable(i_in_active_high) |->
        lk.level == ~($past(i_input_line, 2) ^ i_in_active_high);
  endproperty
  a_in_polarity: assert property (p_in_polarity) // RULE6
    else $error("Input level or polarity wrong.");

  property p_out_map; // RULE8
    @(posedge i_mclk) disable iff (i_reset)
      settle_q[0] |-> o_output_line == $past(exp_chk);
  endproperty
  a_out_map: assert property (p_out_map) // RULE8
    else $error("Output does not follow its state.");

  property p_out_high; // RULE9
    @(posedge i_mclk) disable iff (i_reset)
      settle_q[0] |->
        ((o_output_line ^ $past(hit_chk)) & $past(i_out_active_high)) == '0;
  endproperty
  a_out_high: assert property (p_out_high) // RULE9
    else $error("Active high output wrong.");

  property p_out_off; // RULE10
    @(posedge i_mclk) disable iff (i_reset)
      settle_q[0] |->
        ((o_output_line ^ ~$past(i_out_active_high)) & $past(off_chk)) == '0;
  endproperty
  a_out_off: assert property (p_out_off) // RULE10
    else $error("Disabled output left inactive level.");

  property p_fault_lamp; // RULE13
    @(posedge i_mclk) disable iff (i_reset)
      any_fault |=> o_fault_lamp;
  endproperty
  a_fault_lamp: assert property (p_fault_lamp) // RULE13
    else $error("Fault lamp missed a fault.");

  property p_lamp_clear; // RULE13
    @(posedge i_mclk) disable iff (i_reset)
      !any_fault |=> !o_fault_lamp;
  endproperty
  a_lamp_clear: assert property (p_lamp_clear) // RULE13
    else $error("Fault lamp lit without a fault.");

  property p_finish_measure; // RULE12
    @(posedge i_mclk) disable iff (i_reset)
      i_cal_finish && !span_req && !zero_req |=>
        (cal_q == CAL_MEASURE) && !o_cal_start;
  endproperty
  a_finish_measure: assert property (p_finish_measure) // RULE12
    else $error("Finish did not return to measure.");

  property p_start_cause; // RULE17
    @(posedge i_mclk) disable iff (i_reset)
      o_cal_start |-> $past(span_req) || $past(zero_req);
  endproperty
  a_start_cause: assert property (p_start_cause) // RULE17
    else $error("Start pulse without an input entry.");

  property p_start_once; // RULE3
    @(posedge i_mclk) disable iff (i_reset)
      o_cal_start && !span_req && !zero_req |=> !o_cal_start;
  endproperty
  a_start_once: assert property (p_start_once) // RULE3
    else $error("Start pulse lasted more than one cycle.");

  property p_mode_onehot; // RULE4
    @(posedge i_mclk) disable iff (i_reset)
      $onehot(o_cal_mode);
  endproperty
  a_mode_onehot: assert property (p_mode_onehot) // RULE4
    else $error("Calibration selector not one-hot.");

  property p_mask_quiet; // RULE2
    @(posedge i_mclk) disable iff (i_reset)
      ((lk.rise & (span_mask | zero_mask)) == '0) && !i_cal_finish |=>
        $stable(o_cal_mode);
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) // RULE2
    else $error("Disabled line changed the selector.");

endmodule // dioem_top

// File: verification/dioem_master_model.sv
// Model of the external logger that drives the digital input pins.
`timescale 1ns/100ps
module dioem_master_model
  import dioem_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_slow,
  input wire logic [NUM_IN-1:0] i_want,
  input wire logic [NUM_IN-1:0] i_active_high,
  output logic [NUM_IN-1:0] o_line
);
  logic [NUM_IN-1:0] want_q = 8'h00;
  logic [NUM_IN-1:0] want_sel;

  // Slow answer lags the request by one clock.
  always @(posedge i_mclk) begin
    want_q <= i_want;
  end
  assign want_sel = i_slow ? want_q : i_want;
  assign o_line = ~(want_sel ^ i_active_high);
endmodule // dioem_master_model

// File: verification/tb_top.sv
// Self-checking bench for the digital I/O event mapper.
`timescale 1ns/100ps
module tb_top;
  import dioem_pkg::*;
  typedef struct {int stim; logic [SRC_W-1:0] src;
                  logic [1:0] hl;} dioem_row_s;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  logic slow = 1'b0;
  logic fin = 1'b0;
  logic [NUM_IN-1:0] want = 8'h00;
  logic [NUM_IN-1:0] line;
  logic [NUM_IN*ACT_W-1:0] act = 16'h09C9;
  logic [NUM_IN-1:0] in_ah = 8'hFE;
  logic [NUM_OUT*SRC_W-1:0] osrc = 40'h0;
  logic [NUM_OUT-1:0] out_ah = 8'h0F;
  logic psu, conv, wheel, flow, chas, oth, usb, bgd, mnt;
  logic [NUM_HEAT-1:0] heat;
  logic [2:0] alt;
  logic [NUM_OUT-1:0] o_line;
  logic [2:0] o_mode;
  logic o_start, o_lamp;
  int n_mismatch = 0;
  int tests_run = 0;
  dioem_row_s rows [22];

  // ****************************************
  // Clock, model and design.
  // ****************************************
  initial begin
    forever #5 i_mclk = ~i_mclk;
  end

  dioem_master_model dioem_master_model_inst (.i_mclk(i_mclk), .i_slow(slow),
    .i_want(want), .i_active_high(in_ah), .o_line(line));

  dioem_top dioem_top_inst (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_input_line(line), .i_in_action(act), .i_in_active_high(in_ah),
    .i_out_source(osrc), .i_out_active_high(out_ah), .i_cal_finish(fin),
    .i_psu_fault(psu), .i_converter_fault(conv), .i_wheel_fault(wheel),
    .i_flow_fault(flow), .i_heater_fault(heat), .i_chassis_temp_fault(chas),
    .i_other_fault(oth), .i_usb_present(usb), .i_background_busy(bgd),
    .i_maintenance(mnt), .i_alt_scale(alt), .o_output_line(o_line),
    .o_cal_mode(o_mode), .o_cal_start(o_start), .o_fault_lamp(o_lamp));

  // ****************************************
  // Tasks.
  // ****************************************
  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic step();
    @(posedge i_mclk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic drive_status(input int k);
    psu = (k == 1);
    conv = (k == 2);
    wheel = (k == 3);
    flow = (k == 4);
    chas = (k == 10);
    usb = (k != 11);
    bgd = (k == 12);
    oth = (k == 15);
    mnt = (k == 16);
    heat = 5'h00;
    alt = 3'h0;
    if (k >= 5 && k <= 9) begin
      heat[k-5] = 1'b1;
    end
    if (k >= 17) begin
      alt[k-17] = 1'b1;
    end
  endtask

  task automatic do_reset();
    i_reset = 1'b1;
    repeat (3) step();
    chk(o_line, 8'h00, "reset output");
    chk({5'h00, o_mode}, {5'h00, CAL_MEASURE}, "reset mode");
    chk({7'h00, o_start}, 8'h00, "reset start");
    chk({7'h00, o_lamp}, 8'h00, "reset lamp");
    i_reset = 1'b0;
  endtask

  task automatic quiet(input int n);
    repeat (n) begin
      step();
      chk({7'h00, o_start}, 8'h00, "unexpected start");
    end
  endtask

  task automatic wait_start(input logic [2:0] mode, input logic [7:0] out,
                            input string what);
    int i;
    i = 0;
    while (o_start !== 1'b1 && i < 8) begin
      step();
      i++;
    end
    chk({7'h00, o_start}, 8'h01, what);
    if (i == 8) begin
      end_sim();
    end else begin
      chk({5'h00, o_mode}, {5'h00, mode}, what);
      step();
      chk({7'h00, o_start}, 8'h00, what);
      chk(o_line, out, what);
    end
  endtask

  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    rows = '{'{1, 5'h01, 2'h3}, '{2, 5'h02, 2'h3}, '{3, 5'h03, 2'h3},
      '{4, 5'h04, 2'h3}, '{5, 5'h05, 2'h3}, '{6, 5'h06, 2'h3},
      '{7, 5'h07, 2'h3}, '{8, 5'h08, 2'h3}, '{9, 5'h09, 2'h3},
      '{10, 5'h0A, 2'h3}, '{11, 5'h0B, 2'h2}, '{12, 5'h0C, 2'h2},
      '{15, 5'h0F, 2'h3}, '{16, 5'h10, 2'h2}, '{17, 5'h11, 2'h2},
      '{18, 5'h12, 2'h2}, '{19, 5'h13, 2'h2}, '{1, 5'h00, 2'h1},
      '{1, 5'h0F, 2'h3}, '{16, 5'h14, 2'h0}, '{0, 5'h0B, 2'h0},
      '{1, 5'h02, 2'h1}};
    drive_status(0);
    do_reset();
    foreach (rows[r]) begin
      osrc = {NUM_OUT{rows[r].src}};
      drive_status(rows[r].stim);
      step();
      step();
      chk(o_line, rows[r].hl[1] ? 8'h0F : 8'hF0, "map");
      chk({7'h00, o_lamp}, {7'h00, rows[r].hl[0]}, "lamp");
    end
    drive_status(0);
    osrc = {30'h0, SRC_ZERO, SRC_SPAN};
    out_ah = 8'hFF;
    quiet(6);
    want = 8'h01;
    wait_start(CAL_SPAN, 8'h01, "span");
    quiet(5);
    fin = 1'b1;
    step();
    fin = 1'b0;
    step();
    chk({5'h00, o_mode}, {5'h00, CAL_MEASURE}, "finish");
    chk(o_line, 8'h00, "span cleared");
    slow = 1'b1;
    want = 8'h02;
    wait_start(CAL_ZERO, 8'h02, "zero");
    want = 8'h0C;
    quiet(6);
    chk({5'h00, o_mode}, {5'h00, CAL_ZERO}, "disabled line");
    want = 8'h30;
    wait_start(CAL_SPAN, 8'h01, "span and zero");
    out_ah = 8'h0F;
    drive_status(1);
    do_reset();
    quiet(4);
    chk({5'h00, o_mode}, {5'h00, CAL_MEASURE}, "held line");
    chk(o_line, 8'hF0, "after reset");
    chk({7'h00, o_lamp}, 8'h01, "lamp after reset");
    end_sim();
  end
endmodule // tb_top
